// file: verif/pll_clock_divider_config_tb.sv
// Self-checking bench for the PLL factor, lock count and divider registers.
// Assumes the register port, feedback tick and auto inputs are driven here on ref_clk.
`timescale 1ns/10ps
module pll_clock_divider_config_tb;
  logic ref_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic auto_set_mode = 1'b0;
  logic [5:0] auto_int = 6'h00;
  logic [13:0] auto_frac = 14'h0000;
  logic [3:0] auto_r = 4'h0;
  logic [6:0] auto_dsp_div = 7'h00;
  logic [6:0] auto_dac_div = 7'h00;
  logic [6:0] auto_pump_div = 7'h00;
  logic fb_tick = 1'b0;
  logic lock_flag = 1'b0;
  logic [5:0] pll_int;
  logic [13:0] pll_frac;
  logic [4:0] pll_r_mult;
  logic [23:0] pll_mult;
  logic frac_err;
  logic pll_locked;
  logic dsp_clk_en;
  logic dac_clk_en;
  logic pump_clk_en;
  int bad_count = 0;
  int comparisons = 0;

  pcd_clk_cfg u_pcd_clk_cfg (.ref_clk(ref_clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .auto_set_mode(auto_set_mode), .auto_int(auto_int),
    .auto_frac(auto_frac), .auto_r(auto_r), .auto_dsp_div(auto_dsp_div), .auto_dac_div(auto_dac_div),
    .auto_pump_div(auto_pump_div), .fb_tick(fb_tick), .lock_flag(lock_flag), .pll_int(pll_int),
    .pll_frac(pll_frac), .pll_r_mult(pll_r_mult), .pll_mult(pll_mult), .frac_err(frac_err),
    .pll_locked(pll_locked), .dsp_clk_en(dsp_clk_en), .dac_clk_en(dac_clk_en), .pump_clk_en(pump_clk_en));

  // 200 MHz reference clock
  initial begin
    forever #2.5 ref_clk = ~ref_clk;
  end

  task test_done;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task check(input string name, input logic [23:0] exp, input logic [23:0] got);
    comparisons++;
    if (got !== exp) begin
      $display("unexpected %s: expected %h seen %h", name, exp, got);
      bad_count++;
    end
  endtask

  // One write strobe, taken at the following edge
  task reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask

  // Read data is looked at 1 ns after the edge that takes the strobe
  task rd_check(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    check($sformatf("read %h", a), {16'h0000, exp}, {16'h0000, reg_rdata});
  endtask

  // Settings reach pll_mult two edges after a field change; four gives margin
  task settle;
    repeat (4) @(posedge ref_clk);
    #1;
  endtask

  task tick(input logic flag);
    @(posedge ref_clk);
    fb_tick <= 1'b1;
    lock_flag <= flag;
    @(posedge ref_clk);
    fb_tick <= 1'b0;
    @(posedge ref_clk);
    #1;
  endtask

  function automatic logic en_of(input int sel);
    return (sel == 0) ? dsp_clk_en : (sel == 1) ? dac_clk_en : pump_clk_en;
  endfunction

  // Cycles between two enable pulses; a missing pulse ends the run
  task period_check(input int sel, input int exp);
    int i;
    int n;
    i = 0;
    n = 0;
    do begin
      @(posedge ref_clk);
      #1;
      i++;
    end while (en_of(sel) !== 1'b1 && i < 300);
    do begin
      @(posedge ref_clk);
      #1;
      n++;
    end while (en_of(sel) !== 1'b1 && n < 300);
    if (i >= 300 || n >= 300) begin
      bad_count++;
      test_done();
    end
    check($sformatf("period %0d", sel), 24'(exp), 24'(n));
  endtask

  task automatic test_reset;
    logic [7:0] addrs [7] = '{8'h17, 8'h18, 8'h19, 8'h1A, 8'h1B, 8'h1C, 8'h1D};
    logic [7:0] vals [7] = '{8'h00, 8'h00, 8'h00, 8'h80, 8'h00, 8'h0F, 8'h03};
    for (int k = 0; k < 7; k++) begin
      rd_check(addrs[k], vals[k]);
    end
    rd_check(8'h15, 8'h08);
    check("int", 24'd8, pll_int);
    check("frac", 24'd0, pll_frac);
    check("r_mult", 24'd1, pll_r_mult);
    check("mult", 24'd80000, pll_mult);
    check("frac_err", 24'd0, frac_err);
    check("reset lock", 24'd0, pll_locked);
    reg_write(8'h30, 8'h5A);
    rd_check(8'h30, 8'h00);
    $display("test_reset done");
  endtask

  task test_factor;
    reg_write(8'h15, 8'h03); // J is never zero
    reg_write(8'h16, 8'hC4); // Upper reserved bits must be dropped
    reg_write(8'h17, 8'hD2);
    reg_write(8'h18, 8'hFF);
    settle();
    rd_check(8'h15, 8'h03);
    rd_check(8'h16, 8'h04);
    rd_check(8'h18, 8'h0F);
    check("int", 24'd3, pll_int);
    check("frac", 24'd1234, pll_frac);
    check("r_mult", 24'd16, pll_r_mult);
    check("mult", 24'd499744, pll_mult);
    check("frac_err", 24'd0, frac_err);
    reg_write(8'h16, 8'h27);
    reg_write(8'h17, 8'h10);
    settle();
    check("frac_err", 24'd1, frac_err);
    reg_write(8'h17, 8'h0F);
    settle();
    check("frac_err", 24'd0, frac_err);
    $display("test_factor done");
  endtask

  task test_lock;
    reg_write(8'h19, 8'h03);
    rd_check(8'h1A, 8'h80);
    repeat (3) tick(1'b1);
    check("staged lock", 24'd0, pll_locked);
    tick(1'b0);
    reg_write(8'h1A, 8'h00);
    rd_check(8'h19, 8'h03);
    repeat (2) tick(1'b1);
    check("early lock", 24'd0, pll_locked);
    tick(1'b1);
    check("lock", 24'd1, pll_locked);
    tick(1'b0);
    check("drop lock", 24'd0, pll_locked);
    tick(1'b1);
    check("recount", 24'd0, pll_locked);
    $display("test_lock done");
  endtask

  task test_div;
    period_check(1, 16);
    period_check(2, 4);
    reg_write(8'h1B, 8'h00);
    reg_write(8'h1C, 8'hFF);
    reg_write(8'h1D, 8'h04);
    rd_check(8'h1C, 8'h7F);
    period_check(0, 1);
    period_check(1, 128);
    period_check(2, 5);
    reg_write(8'h1B, 8'h7F);
    period_check(0, 128);
    $display("test_div done");
  endtask

  task test_auto;
    @(posedge ref_clk);
    auto_set_mode <= 1'b1;
    auto_int <= 6'h05;
    auto_frac <= 14'h270F;
    auto_r <= 4'h1;
    auto_dsp_div <= 7'h02;
    auto_dac_div <= 7'h05;
    auto_pump_div <= 7'h00;
    settle();
    check("auto int", 24'd5, pll_int);
    check("auto frac", 24'd9999, pll_frac);
    check("auto r", 24'd2, pll_r_mult);
    check("auto frac_err", 24'd0, frac_err);
    check("auto mult", 24'd119998, pll_mult);
    period_check(0, 3);
    period_check(1, 6);
    period_check(2, 1);
    rd_check(8'h1B, 8'h7F);
    @(posedge ref_clk);
    auto_set_mode <= 1'b0;
    settle();
    check("manual r", 24'd16, pll_r_mult);
    check("manual int", 24'd3, pll_int);
    $display("test_auto done");
  endtask

  // Main sequence
  initial begin
    repeat (10) @(posedge ref_clk);
    sys_rst <= 1'b0;
    test_reset();
    test_factor();
    test_lock();
    test_div();
    test_auto();
    test_done();
  end
endmodule

// file: verilog/pcd_clk_cfg.sv
// PLL factor, lock count and clock divider configuration registers.
// Assumes a byte register port from the control-port decoder, synchronous to ref_clk,
// and a feedback-clock enable and lock flag from the PLL, also synchronous.
//
// What this block does
// [R1] Low byte holds D bits 7-0, max 9999
// [R2] Overall PLL factor is J.D times R
// [R3] R field encodes R as value plus one
// [R4] Auto set mode overrides manual factor fields
// [R5] Lock after threshold consecutive feedback lock flags
// [R6] Threshold applied only on upper byte write
// [R7] Host writes lower lock byte first
// [R8] DSP divider divides by value plus one
// [R9] DAC divider divides by value plus one
// [R10] Pump divider divides by value plus one
// [R11] D upper bits in bits 5-0 below
// [R12] Host never programs J as zero
// [R13] Missing lock flag restarts count, clears lock
`timescale 1ns/10ps
module pcd_clk_cfg (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // Clock auto set mode and its derived settings
  input wire logic auto_set_mode,
  input wire logic [5:0] auto_int,
  input wire logic [13:0] auto_frac,
  input wire logic [3:0] auto_r,
  input wire logic [6:0] auto_dsp_div,
  input wire logic [6:0] auto_dac_div,
  input wire logic [6:0] auto_pump_div,
  // PLL feedback side
  input wire logic fb_tick,
  input wire logic lock_flag,
  // PLL settings in use
  output logic [5:0] pll_int,
  output logic [13:0] pll_frac,
  output logic [4:0] pll_r_mult,
  output logic [23:0] pll_mult,
  output logic frac_err,
  output logic pll_locked,
  // Divided clock enables
  output logic dsp_clk_en,
  output logic dac_clk_en,
  output logic pump_clk_en
);

  // Programmed fields
  logic [5:0] int_field_q;
  logic [5:0] frac_hi_q;
  logic [7:0] frac_lo_q;
  logic [3:0] r_field_q;
  logic [7:0] lock_lo_q;
  logic [15:0] lock_thr_q;
  logic [6:0] dsp_div_q;
  logic [6:0] dac_div_q;
  logic [6:0] pump_div_q;
  // Settings in use
  logic [5:0] int_q;
  logic [13:0] frac_q;
  logic [4:0] r_mult_q;
  logic [23:0] mult_q;
  logic frac_err_q;
  logic [6:0] dsp_eff_q;
  logic [6:0] dac_eff_q;
  logic [6:0] pump_eff_q;
  logic [7:0] rdata_q;
  // Lock detector
  pcd_pkg::pcd_lock_state_t lock_state_q;
  logic [15:0] lock_cnt_q;
  logic [16:0] cnt_next;
  logic wr_lcnt_hi;

  // Picks the automatic value while auto set mode is active
  function automatic logic [6:0] pcd_pick7(input logic auto_on, input logic [6:0] a, input logic [6:0] m);
    pcd_pick7 = auto_on ? a : m;
  endfunction

  // Overall factor scaled by 10000: (J * 10000 + D) * R
  function automatic logic [23:0] pcd_factor(input logic [5:0] j, input logic [13:0] d, input logic [4:0] r);
    logic [23:0] jd;
    jd = 24'(24'(j) * pcd_pkg::D_SCALE) + 24'(d);
    pcd_factor = 24'(jd * 24'(r));
  endfunction

  assign wr_lcnt_hi = reg_wr && (reg_addr == pcd_pkg::ADDR_LCNT_HI);
  assign cnt_next = {1'b0, lock_cnt_q} + 17'h00001;

  // Register writes; reserved bits are dropped
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      int_field_q <= pcd_pkg::RST_INT;
      frac_hi_q <= pcd_pkg::RST_FRAC_HI;
      frac_lo_q <= pcd_pkg::RST_FRAC_LO;
      r_field_q <= pcd_pkg::RST_R;
      dsp_div_q <= pcd_pkg::RST_DSP;
      dac_div_q <= pcd_pkg::RST_DAC;
      pump_div_q <= pcd_pkg::RST_PUMP;
    end else if (reg_wr) begin
      case (reg_addr)
        pcd_pkg::ADDR_INT: int_field_q <= reg_wdata[5:0];
        pcd_pkg::ADDR_FRAC_HI: frac_hi_q <= reg_wdata[5:0]; // see [R11]
        pcd_pkg::ADDR_FRAC_LO: frac_lo_q <= reg_wdata; // see [R1]
        pcd_pkg::ADDR_R: r_field_q <= reg_wdata[3:0];
        pcd_pkg::ADDR_DSP: dsp_div_q <= reg_wdata[6:0];
        pcd_pkg::ADDR_DAC: dac_div_q <= reg_wdata[6:0];
        pcd_pkg::ADDR_PUMP: pump_div_q <= reg_wdata[6:0];
        default: ;
      endcase
    end
  end

  // Lock count: low byte is only staged, the pair goes live on the upper byte write
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      lock_lo_q <= pcd_pkg::RST_LCNT_LO;
      lock_thr_q <= {pcd_pkg::RST_LCNT_HI, pcd_pkg::RST_LCNT_LO};
    end else begin
      if (reg_wr && reg_addr == pcd_pkg::ADDR_LCNT_LO) begin
        lock_lo_q <= reg_wdata; // see [R7]
      end
      if (wr_lcnt_hi) begin
        lock_thr_q <= {reg_wdata, lock_lo_q}; // see [R6]
      end
    end
  end

  // Read data one cycle after the strobe; unmapped addresses read zero
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      case (reg_addr)
        pcd_pkg::ADDR_INT: rdata_q <= {2'h0, int_field_q};
        pcd_pkg::ADDR_FRAC_HI: rdata_q <= {2'h0, frac_hi_q};
        pcd_pkg::ADDR_FRAC_LO: rdata_q <= frac_lo_q;
        pcd_pkg::ADDR_R: rdata_q <= {4'h0, r_field_q};
        pcd_pkg::ADDR_LCNT_LO: rdata_q <= lock_lo_q;
        pcd_pkg::ADDR_LCNT_HI: rdata_q <= lock_thr_q[15:8];
        pcd_pkg::ADDR_DSP: rdata_q <= {1'b0, dsp_div_q};
        pcd_pkg::ADDR_DAC: rdata_q <= {1'b0, dac_div_q};
        pcd_pkg::ADDR_PUMP: rdata_q <= {1'b0, pump_div_q};
        default: rdata_q <= 8'h00;
      endcase
    end
  end

  // Factor selection; auto mode takes precedence over every manual field
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      int_q <= pcd_pkg::RST_INT;
      frac_q <= {pcd_pkg::RST_FRAC_HI, pcd_pkg::RST_FRAC_LO};
      r_mult_q <= 5'h01;
      frac_err_q <= 1'b0;
    end else if (auto_set_mode) begin // see [R4]
      int_q <= auto_int;
      frac_q <= auto_frac;
      r_mult_q <= {1'b0, auto_r} + 5'h01;
      frac_err_q <= auto_frac > pcd_pkg::D_MAX;
    end else begin
      int_q <= int_field_q;
      frac_q <= {frac_hi_q, frac_lo_q}; // see [R11]
      r_mult_q <= {1'b0, r_field_q} + 5'h01; // see [R3]
      frac_err_q <= {frac_hi_q, frac_lo_q} > pcd_pkg::D_MAX; // see [R1]
    end
  end

  // Overall factor follows the selected fields one cycle later
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      mult_q <= 24'h000000;
    end else begin
      mult_q <= pcd_factor(int_q, frac_q, r_mult_q); // see [R2]
    end
  end

  // Divider values in use
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      dsp_eff_q <= pcd_pkg::RST_DSP;
      dac_eff_q <= pcd_pkg::RST_DAC;
      pump_eff_q <= pcd_pkg::RST_PUMP;
    end else begin
      dsp_eff_q <= pcd_pick7(auto_set_mode, auto_dsp_div, dsp_div_q); // see [R4]
      dac_eff_q <= pcd_pick7(auto_set_mode, auto_dac_div, dac_div_q);
      pump_eff_q <= pcd_pick7(auto_set_mode, auto_pump_div, pump_div_q);
    end
  end

  // Lock detector; a threshold of zero locks on the first flag seen
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      lock_state_q <= pcd_pkg::PCD_HUNT;
      lock_cnt_q <= 16'h0000;
    end else if (fb_tick) begin
      if (!lock_flag) begin
        lock_state_q <= pcd_pkg::PCD_HUNT; // see [R13]
        lock_cnt_q <= 16'h0000;
      end else begin
        if (lock_cnt_q != pcd_pkg::LCNT_SAT) begin
          lock_cnt_q <= cnt_next[15:0];
        end
        case (lock_state_q)
          pcd_pkg::PCD_HUNT: begin
            if (cnt_next >= {1'b0, lock_thr_q}) begin
              lock_state_q <= pcd_pkg::PCD_LOCKED; // see [R5]
            end
          end
          pcd_pkg::PCD_LOCKED: lock_state_q <= pcd_pkg::PCD_LOCKED;
          default: lock_state_q <= pcd_pkg::PCD_HUNT;
        endcase
      end
    end
  end

  // Divided clock enables
  pcd_clk_div u_dsp_div (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .div_val(dsp_eff_q),
    .tick_q(dsp_clk_en)
  );
  pcd_clk_div u_dac_div (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .div_val(dac_eff_q),
    .tick_q(dac_clk_en)
  );
  pcd_clk_div u_pump_div (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .div_val(pump_eff_q),
    .tick_q(pump_clk_en)
  );

  // Outputs straight from flops
  assign reg_rdata = rdata_q;
  assign pll_int = int_q;
  assign pll_frac = frac_q;
  assign pll_r_mult = r_mult_q;
  assign pll_mult = mult_q;
  assign frac_err = frac_err_q;
  // One-hot state, so the lock status is the locked state bit itself
  assign pll_locked = lock_state_q[1];

  // Checks
  a_frac_range: assert property (@(posedge ref_clk) disable iff (sys_rst) // see [R1]
    frac_err_q == (frac_q > pcd_pkg::D_MAX))
    else $error("fraction range flag disagrees with fraction");
  a_factor_value: assert property (@(posedge ref_clk) disable iff (sys_rst) // see [R2]
    !$past(sys_rst) |-> mult_q == 24'(($past(24'(int_q)) * 24'h002710 + $past(24'(frac_q))) * $past(24'(r_mult_q))))
    else $error("overall factor wrong");
  a_r_encode: assert property (@(posedge ref_clk) disable iff (sys_rst) // see [R3]
    !$past(sys_rst) && !$past(auto_set_mode) |-> r_mult_q == $past({1'b0, r_field_q}) + 5'h01)
    else $error("R multiplier is not field plus one");
  a_auto_override: assert property (@(posedge ref_clk) disable iff (sys_rst) // see [R4]
    auto_set_mode |=> int_q == $past(auto_int) && frac_q == $past(auto_frac) && dsp_eff_q == $past(auto_dsp_div))
    else $error("manual field used in auto set mode");
  a_lock_reach: assert property (@(posedge ref_clk) disable iff (sys_rst) // see [R5]
    !pll_locked ##1 pll_locked |-> $past(fb_tick) && $past(lock_flag) && $past(cnt_next) >= {1'b0, $past(lock_thr_q)})
    else $error("lock declared before threshold count");
  a_thr_staged: assert property (@(posedge ref_clk) disable iff (sys_rst) // see [R6]
    !wr_lcnt_hi |=> $stable(lock_thr_q))
    else $error("threshold changed without upper byte write");
  a_thr_apply: assert property (@(posedge ref_clk) disable iff (sys_rst) // see [R6]
    wr_lcnt_hi |=> lock_thr_q == {$past(reg_wdata), $past(lock_lo_q)})
    else $error("threshold not applied from staged pair");
  a_frac_join: assert property (@(posedge ref_clk) disable iff (sys_rst) // see [R11]
    !$past(sys_rst) && !$past(auto_set_mode) |-> frac_q == {$past(frac_hi_q), $past(frac_lo_q)})
    else $error("fraction not built from high and low fields");
  a_lock_drop: assert property (@(posedge ref_clk) disable iff (sys_rst) // see [R13]
    fb_tick && !lock_flag |=> !pll_locked && lock_cnt_q == 16'h0000)
    else $error("missing lock flag did not restart count");
  a_div_manual: assert property (@(posedge ref_clk) disable iff (sys_rst) // see [R9]
    !auto_set_mode |=> dac_eff_q == $past(dac_div_q) && pump_eff_q == $past(pump_div_q))
    else $error("manual divider not applied");
  a_int_select: assert property (@(posedge ref_clk) disable iff (sys_rst) // see [R2]
    !$past(sys_rst) && !$past(auto_set_mode) |-> int_q == $past(int_field_q))
    else $error("J in use is not the programmed field");
  a_div_auto: assert property (@(posedge ref_clk) disable iff (sys_rst) // see [R4]
    auto_set_mode |=> dac_eff_q == $past(auto_dac_div) && pump_eff_q == $past(auto_pump_div))
    else $error("manual divider used in auto set mode");
  a_frac_store: assert property (@(posedge ref_clk) disable iff (sys_rst) // see [R1]
    reg_wr && reg_addr == pcd_pkg::ADDR_FRAC_LO |=> frac_lo_q == $past(reg_wdata))
    else $error("fraction low byte not stored");
  // Lock survives threshold rewrites; only a missing flag may drop it
  a_lock_hold: assert property (@(posedge ref_clk) disable iff (sys_rst) // see [R5]
    pll_locked && !(fb_tick && !lock_flag) |=> pll_locked)
    else $error("lock dropped without a missing flag");
  a_lock_count: assert property (@(posedge ref_clk) disable iff (sys_rst) // see [R5]
    fb_tick && lock_flag && lock_cnt_q != pcd_pkg::LCNT_SAT |=> lock_cnt_q == $past(lock_cnt_q) + 16'h0001)
    else $error("consecutive lock flags not counted");

  c_locked: cover property (@(posedge ref_clk) disable iff (sys_rst) !pll_locked ##1 pll_locked);
  c_frac_err: cover property (@(posedge ref_clk) disable iff (sys_rst) $rose(frac_err_q));
  c_auto_entry: cover property (@(posedge ref_clk) disable iff (sys_rst) !auto_set_mode ##1 auto_set_mode);
  c_thr_write: cover property (@(posedge ref_clk) disable iff (sys_rst)
    reg_wr && reg_addr == pcd_pkg::ADDR_LCNT_LO ##[1:8] wr_lcnt_hi);
  c_lock_lost: cover property (@(posedge ref_clk) disable iff (sys_rst) pll_locked ##1 !pll_locked);

endmodule

// file: verilog/pcd_clk_div.sv
// Source clock divider producing a one-cycle enable every (value + 1) cycles.
// Assumes the source clock is ref_clk; the divide value may change at any time.
`timescale 1ns/10ps
module pcd_clk_div (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // Divider field, divide by value plus one
  input wire logic [6:0] div_val,
  // Divided clock enable
  output logic tick_q
);

  logic [6:0] cnt_q;

  // Wrap on >= so a smaller new value takes effect without a long runout
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      cnt_q <= 7'h00;
      tick_q <= 1'b0;
    end else if (cnt_q >= div_val) begin // see [R8] see [R9] see [R10]
      cnt_q <= 7'h00;
      tick_q <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 7'h01;
      tick_q <= 1'b0;
    end
  end

  // Period check at divide by four, and no back-to-back ticks above divide by one
  a_div_period: assert property (@(posedge ref_clk) disable iff (sys_rst) // see [R8]
    (tick_q && div_val == 7'h03) ##1 (div_val == 7'h03)[*3] |=> tick_q)
    else $error("divider period is not value plus one");
  a_div_gap: assert property (@(posedge ref_clk) disable iff (sys_rst) // see [R9]
    tick_q && div_val != 7'h00 && $stable(div_val) |=> !tick_q)
    else $error("divider ticked twice in a row");

endmodule

// file: verilog/pcd_pkg.sv
// Constants for the PLL and clock divider configuration block.
// Assumes a byte-wide register port fed by the device's control-port decoder.
package pcd_pkg;

  // Register addresses on the control port
  localparam logic [7:0] ADDR_INT = 8'h15;
  localparam logic [7:0] ADDR_FRAC_HI = 8'h16;
  localparam logic [7:0] ADDR_FRAC_LO = 8'h17;
  localparam logic [7:0] ADDR_R = 8'h18;
  localparam logic [7:0] ADDR_LCNT_LO = 8'h19;
  localparam logic [7:0] ADDR_LCNT_HI = 8'h1A;
  localparam logic [7:0] ADDR_DSP = 8'h1B;
  localparam logic [7:0] ADDR_DAC = 8'h1C;
  localparam logic [7:0] ADDR_PUMP = 8'h1D;

  // Field widths
  localparam int INT_W = 6;
  localparam int FRAC_W = 14;
  localparam int FRAC_HI_W = 6;
  localparam int R_W = 4;
  localparam int DIV_W = 7;
  localparam int LCNT_W = 16;
  localparam int MULT_W = 24;

  // Values after reset
  localparam logic [5:0] RST_INT = 6'h08;
  localparam logic [5:0] RST_FRAC_HI = 6'h00;
  localparam logic [7:0] RST_FRAC_LO = 8'h00;
  localparam logic [3:0] RST_R = 4'h0;
  localparam logic [7:0] RST_LCNT_LO = 8'h00;
  localparam logic [7:0] RST_LCNT_HI = 8'h80;
  localparam logic [6:0] RST_DSP = 7'h00;
  localparam logic [6:0] RST_DAC = 7'h0F;
  localparam logic [6:0] RST_PUMP = 7'h03;

  // Fraction is held in decimal, 0 to 9999; one unit of J is 10000 units of D
  localparam logic [13:0] D_MAX = 14'h270F;
  localparam logic [23:0] D_SCALE = 24'h002710;
  localparam logic [15:0] LCNT_SAT = 16'hFFFF;

  // Lock detector states
  typedef enum logic [1:0] {
    PCD_HUNT = 2'b01,
    PCD_LOCKED = 2'b10
  } pcd_lock_state_t;

endpackage
